// ---- pkg/flash_read_pkg.sv ----
// shared constants and types for the burst flash read interface
package flash_read_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W  = 19;
	localparam int DATA_W  = 32;
	localparam int OFF_W   = 3;
	localparam int DLY_W   = 4;
	localparam int CNT_W   = 5;
	localparam int SECT_LO = 11;
	localparam int SECT_W  = 8;

	// ==========================================================
	// burst length select
	typedef logic [1:0] blen_t;
	localparam blen_t BLEN_2 = 2'h0;
	localparam blen_t BLEN_4 = 2'h1;
	localparam blen_t BLEN_8 = 2'h2;
	localparam logic [OFF_W-1:0] MASK_2 = 3'h1;
	localparam logic [OFF_W-1:0] MASK_4 = 3'h3;
	localparam logic [OFF_W-1:0] MASK_8 = 3'h7;

	// ==========================================================
	// initial delay: field 0 means this many clocks
	localparam logic [CNT_W-1:0] DELAY_BASE = 5'h02;
	localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;

	// ==========================================================
	// identification code select on low address bits
	localparam logic [3:0] SEL_MFR  = 4'h0;
	localparam logic [3:0] SEL_DEV1 = 4'h1;
	localparam logic [3:0] SEL_PROT = 4'h2;
	localparam logic [3:0] SEL_DEV2 = 4'he;
	localparam logic [3:0] SEL_DEV3 = 4'hf;
	localparam int         ID_A6    = 6;
	localparam int         ID_W     = 8;

	// ==========================================================
	// secured otp region size in double words
	localparam int OTP_WORDS = 64;

	// ==========================================================
	// configuration read layout: {delay, length, burst enable}
	localparam int CFG_EN_BIT  = 0;
	localparam int CFG_LEN_LO  = 1;
	localparam int CFG_DLY_LO  = 3;

	typedef enum logic [2:0] {
		SEQ_IDLE   = 3'h1,
		SEQ_WAIT   = 3'h2,
		SEQ_STREAM = 3'h4
	} seq_state_e;

endpackage : flash_read_pkg

// ---- pkg/burst_seq_if.sv ----
// carrier between the read front end and the burst sequencer
`timescale 1ns/1ps
interface burst_seq_if;
	import flash_read_pkg::*;

	logic                 start;
	logic                 abort;
	logic                 clk_rise;
	logic [OFF_W-1:0]     start_off;
	blen_t                len_sel;
	logic [DLY_W-1:0]     delay;
	logic                 active;
	logic                 fire;
	logic                 is_last;
	logic [OFF_W-1:0]     cur_off;

	modport ctl (
		output start, abort, clk_rise, start_off, len_sel, delay,
		input  active, fire, is_last, cur_off
	);
	modport seq (
		input  start, abort, clk_rise, start_off, len_sel, delay,
		output active, fire, is_last, cur_off
	);
endinterface : burst_seq_if

// ---- hdl/burst_sequencer.sv ----
// burst sequencer: initial delay count, wrapping offset, last-transfer mark
`timescale 1ns/1ps
module burst_sequencer
	import flash_read_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// front end
	burst_seq_if.seq  b
);

	// ==========================================================
	// state
	seq_state_e           state_ff;
	logic [CNT_W-1:0]     cnt_ff;
	logic [OFF_W-1:0]     off_ff;
	logic [OFF_W-1:0]     last_ff;
	logic [OFF_W-1:0]     mask_ff;
	logic [OFF_W-1:0]     nxt_mask;
	logic [OFF_W-1:0]     nxt_off;
	logic [OFF_W-1:0]     start_last;

	always_comb begin
		unique case (b.len_sel)
			BLEN_2: nxt_mask = MASK_2;
			BLEN_4: nxt_mask = MASK_4;
			default: nxt_mask = MASK_8;
		endcase
	end

	// wrap inside the aligned group
	assign nxt_off = (off_ff & ~mask_ff) | ((off_ff + 3'h1) & mask_ff);
	assign start_last = (b.start_off & ~nxt_mask)
		| ((b.start_off - 3'h1) & nxt_mask);

	assign b.fire = b.clk_rise
		&& ((state_ff == SEQ_WAIT && cnt_ff == CNT_ONE)
		|| state_ff == SEQ_STREAM);
	assign b.is_last = (off_ff == last_ff);
	assign b.cur_off = off_ff;
	assign b.active  = (state_ff != SEQ_IDLE);

	// ==========================================================
	// sequencing
	always_ff @(posedge clk) begin
		if (srst || b.abort) begin
			state_ff <= SEQ_IDLE;
		end else if (b.start) begin
			state_ff <= SEQ_WAIT;
		end else if (b.fire) begin
			state_ff <= SEQ_STREAM;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff <= DELAY_BASE;
		end else if (b.start) begin
			cnt_ff <= DELAY_BASE + {1'b0, b.delay};
		end else if (b.clk_rise && state_ff == SEQ_WAIT && cnt_ff != CNT_ONE) begin
			cnt_ff <= cnt_ff - CNT_ONE;
		end
	end

	// after the last transfer the offset returns to the start
	always_ff @(posedge clk) begin
		if (srst) begin
			off_ff  <= '0;
			last_ff <= '0;
			mask_ff <= MASK_8;
		end else if (b.start) begin
			off_ff  <= b.start_off;
			last_ff <= start_last;
			mask_ff <= nxt_mask;
		end else if (b.fire) begin
			off_ff <= nxt_off;
		end
	end

endmodule : burst_sequencer

// ---- hdl/flash_read_top.sv ----
// read side of a 32-bit burst flash: async reads, identification, bursts
//
// Functional notes
// - identification mode outputs codes on low byte
// - command sequence enters identification without voltage
// - power-up starts in asynchronous read mode
// - drive outputs only with select and gate
// - linear bursts of 2, 4, 8 wrap
// - initial delay selectable over clock counts
// - burst enabled means array reads burst
// - otp region read with array timing
// - config and protection reads stay single-cycle
// - end flag low on final transfer
// - keep clocking wraps to burst start
// - end flag floats when not asserted
// - start address, increment modulo length
// - chip deselect abandons burst, floats outputs
// - capture address at edge or valid rise
// - delay field zero gives two clocks
// - hardware reset ends burst, async mode
// - gate high floats pins, burst continues
`timescale 1ns/1ps
module flash_read_top
	import flash_read_pkg::*;
#(
	parameter logic [ID_W-1:0] MFR_CODE  = 8'h5a, // arbitrary value
	parameter logic [ID_W-1:0] DEV_CODE1 = 8'h11, // arbitrary value
	parameter logic [ID_W-1:0] DEV_CODE2 = 8'h22, // arbitrary value
	parameter logic [ID_W-1:0] DEV_CODE3 = 8'h33  // arbitrary value
)(
	// clock and reset
	input  wire logic                   CLK,
	input  wire logic                   SRST,
	// flash pins from the host
	input  wire logic                   RESET_N,
	input  wire logic                   CHIP_SELECT_N,
	input  wire logic                   OUTPUT_GATE_N,
	input  wire logic                   ADDRESS_VALID_N,
	input  wire logic                   BURST_CLK,
	input  wire logic                   ID_HIGH_VOLTAGE,
	input  wire logic [ADDR_W-1:0]      ADDR,
	// flash pins to the host
	output logic [DATA_W-1:0]           DQ,
	output logic                        DQ_OE_N,
	output logic                        BURST_END_FLAG_N,
	output logic                        BURST_END_FLAG_OE_N,
	// command decoder side
	input  wire logic                   ID_MODE,
	input  wire logic                   CFG_READ,
	input  wire logic                   CFG_WRITE,
	input  wire logic                   CFG_BURST_EN,
	input  wire blen_t                  CFG_LEN,
	input  wire logic [DLY_W-1:0]       CFG_DELAY,
	input  wire logic                   OTP_SELECT,
	input  wire logic [(1<<SECT_W)-1:0] SECTOR_PROTECT,
	// array read port, data one cycle after address
	output logic [ADDR_W-1:0]           ARRAY_ADDR,
	output logic                        ARRAY_OTP,
	input  wire logic [DATA_W-1:0]      ARRAY_RDATA
);

	// ==========================================================
	// pin synchronisers
	localparam int PIN_W = ADDR_W + 6;
	logic [PIN_W-1:0] pin_s1_ff;
	logic [PIN_W-1:0] pin_s2_ff;
	always_ff @(posedge CLK) begin
		pin_s1_ff <= {RESET_N, CHIP_SELECT_N, OUTPUT_GATE_N,
			ADDRESS_VALID_N, BURST_CLK, ID_HIGH_VOLTAGE, ADDR};
		pin_s2_ff <= pin_s1_ff;
	end

	logic              hw_rst;
	logic              ce;
	logic              oe;
	logic              adv_low;
	logic              bclk;
	logic              hv;
	logic [ADDR_W-1:0] addr;
	assign {hw_rst, ce, oe, adv_low, bclk, hv, addr} =
		{~pin_s2_ff[PIN_W-1], ~pin_s2_ff[PIN_W-2], ~pin_s2_ff[PIN_W-3],
		~pin_s2_ff[PIN_W-4], pin_s2_ff[PIN_W-5], pin_s2_ff[PIN_W-6],
		pin_s2_ff[ADDR_W-1:0]};

	logic bclk_d_ff;
	logic adv_low_d_ff;
	always_ff @(posedge CLK) begin
		bclk_d_ff    <= bclk;
		adv_low_d_ff <= adv_low;
	end
	logic bclk_rise;
	logic adv_rise;
	logic adv_fall;
	assign bclk_rise = bclk & ~bclk_d_ff;
	assign adv_rise  = adv_low_d_ff & ~adv_low;
	assign adv_fall  = adv_low & ~adv_low_d_ff;

	logic rst_all;
	assign rst_all = SRST || hw_rst;

	// ==========================================================
	// configuration, cleared to async mode by any reset
	logic        burst_en_ff;
	blen_t       len_ff;
	logic [DLY_W-1:0] dly_ff;
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			burst_en_ff <= 1'b0;
			len_ff      <= BLEN_8;
			dly_ff      <= '0;
		end else if (CFG_WRITE) begin
			burst_en_ff <= CFG_BURST_EN;
			len_ff      <= CFG_LEN;
			dly_ff      <= CFG_DELAY;
		end
	end

	// identification and config reads never burst
	logic id_mode;
	logic burst_path;
	assign id_mode    = ID_MODE || hv;
	assign burst_path = burst_en_ff && !id_mode && !CFG_READ;

	// ==========================================================
	// burst start and abort
	burst_seq_if bi ();
	logic captured_ff;
	logic capture;
	// a valid fall on a clock rise restarts at once instead of dropping it
	assign capture = burst_path && ce && !hw_rst
		&& (!captured_ff || adv_fall)
		&& ((adv_low && bclk_rise) || adv_rise);

	always_ff @(posedge CLK) begin
		if (rst_all || !ce) begin
			captured_ff <= 1'b0;
		end else if (capture) begin
			captured_ff <= 1'b1;
		end else if (adv_fall) begin
			captured_ff <= 1'b0;
		end
	end

	logic [ADDR_W-1:0] base_ff;
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			base_ff <= '0;
		end else if (capture) begin
			base_ff <= addr;
		end
	end

	// a second valid pulse discards the running burst
	assign bi.start     = capture;
	assign bi.abort     = hw_rst || !ce
		|| (adv_fall && !capture);
	assign bi.clk_rise  = bclk_rise && !capture;
	assign bi.start_off = addr[OFF_W-1:0];
	assign bi.len_sel   = len_ff;
	assign bi.delay     = dly_ff;

	burst_sequencer u_seq (
		.clk  (CLK),
		.srst (SRST),
		.b    (bi)
	);

	// ==========================================================
	// array addressing; otp region uses the same path
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			ARRAY_ADDR <= '0;
			ARRAY_OTP  <= 1'b0;
		end else begin
			ARRAY_OTP <= OTP_SELECT;
			if (bi.active) begin
				ARRAY_ADDR <= {base_ff[ADDR_W-1:OFF_W], bi.cur_off};
			end else begin
				ARRAY_ADDR <= addr;
			end
		end
	end

	// ==========================================================
	// single-cycle read data: id codes, protection, config
	logic [3:0]        id_sel;
	logic [ID_W-1:0]   id_code;
	logic [DATA_W-1:0] single_data;
	assign id_sel = addr[3:0];
	always_comb begin
		unique case (id_sel)
			SEL_MFR:  id_code = MFR_CODE;
			SEL_DEV1: id_code = DEV_CODE1;
			SEL_DEV2: id_code = DEV_CODE2;
			SEL_DEV3: id_code = DEV_CODE3;
			SEL_PROT: id_code = {7'h00,
				SECTOR_PROTECT[addr[SECT_LO +: SECT_W]]};
			default:  id_code = '0;
		endcase
		// codes only answer with the selecting bit six low
		if (addr[ID_A6]) begin
			id_code = '0;
		end
	end

	always_comb begin
		single_data = '0;
		if (id_mode) begin
			single_data[ID_W-1:0] = id_code;
		end else if (CFG_READ) begin
			single_data[CFG_EN_BIT] = burst_en_ff;
			single_data[CFG_LEN_LO +: 2] = len_ff;
			single_data[CFG_DLY_LO +: DLY_W] = dly_ff;
		end else begin
			single_data = ARRAY_RDATA;
		end
	end

	// ==========================================================
	// data and end flag; gate high floats pins, sequencing runs on
	logic drive;
	logic end_low_ff;
	logic nxt_end_low;
	assign drive = ce && oe && !hw_rst;

	always_comb begin
		nxt_end_low = end_low_ff;
		if (!bi.active || bi.abort || bi.start) begin
			nxt_end_low = 1'b0;
		end else if (bi.fire) begin
			nxt_end_low = bi.is_last;
		end
	end

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			end_low_ff <= 1'b0;
		end else begin
			end_low_ff <= nxt_end_low;
		end
	end

	always_ff @(posedge CLK) begin
		if (rst_all) begin
			DQ <= '0;
		end else if (!burst_path) begin
			DQ <= single_data;
		end else if (bi.fire) begin
			DQ <= ARRAY_RDATA;
		end
	end

	// the flag pin is only ever driven low
	always_ff @(posedge CLK) begin
		if (rst_all) begin
			DQ_OE_N             <= 1'b1;
			BURST_END_FLAG_N    <= 1'b1;
			BURST_END_FLAG_OE_N <= 1'b1;
		end else begin
			DQ_OE_N             <= !drive;
			BURST_END_FLAG_N    <= 1'b0;
			BURST_END_FLAG_OE_N <= !(drive && nxt_end_low);
		end
	end

endmodule : flash_read_top

// ---- sim/flash_array_model.sv ----
// array contents model: one clock read latency, word derived from address
`timescale 1ns/1ps
module flash_array_model
	import flash_read_pkg::*;
(
	// clock
	input  wire logic              clk,
	// read port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              otp,
	output logic      [DATA_W-1:0] rdata
);
	// ==========================================================
	// read path
	// otp bit folded into the word so region mix-ups show
	always_ff @(posedge clk) begin
		rdata <= {otp, 12'h5a5, addr};
	end
endmodule : flash_array_model

// ---- sim/flash_read_top_assertions.sv ----
// concurrent checks on the pins of the burst flash read interface
`timescale 1ns/1ps
module flash_read_checker
	import flash_read_pkg::*;
(
	// clock and reset
	input wire logic              CLK,
	input wire logic              SRST,
	// host pins
	input wire logic              RESET_N,
	input wire logic              CHIP_SELECT_N,
	input wire logic              OUTPUT_GATE_N,
	// command side
	input wire logic              ID_MODE,
	input wire logic              CFG_READ,
	input wire logic              OTP_SELECT,
	// outputs
	input wire logic [DATA_W-1:0] DQ,
	input wire logic              DQ_OE_N,
	input wire logic              BURST_END_FLAG_N,
	input wire logic              BURST_END_FLAG_OE_N,
	input wire logic [ADDR_W-1:0] ARRAY_ADDR,
	input wire logic              ARRAY_OTP
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	// ==========================================================
	// sequences
	// five samples cover the two sync stages plus output register
	sequence deselected; CHIP_SELECT_N [*5]; endsequence
	sequence gated_off; OUTPUT_GATE_N [*5]; endsequence
	sequence pin_reset; !RESET_N [*5]; endsequence
	sequence id_shown; (ID_MODE && !CFG_READ) [*8] ##0 !DQ_OE_N; endsequence
	sequence cfg_shown; CFG_READ [*8] ##0 !DQ_OE_N; endsequence
	sequence otp_steady; ($stable(OTP_SELECT) && RESET_N) [*6]; endsequence

	// ==========================================================
	// assertions
	chk_deselect_float: assert property (deselected |->
		DQ_OE_N && BURST_END_FLAG_OE_N) else $error("drive while deselected");
	chk_gate_float: assert property (gated_off |->
		DQ_OE_N && BURST_END_FLAG_OE_N) else $error("drive while gated off");
	chk_reset_float: assert property (pin_reset |->
		DQ_OE_N && BURST_END_FLAG_OE_N && ARRAY_ADDR == '0)
		else $error("reset pin ignored");
	chk_flag_level: assert property (!BURST_END_FLAG_OE_N |->
		!BURST_END_FLAG_N) else $error("end flag driven high");
	chk_flag_with_data: assert property (!BURST_END_FLAG_OE_N |->
		!DQ_OE_N) else $error("end flag driven without data");
	chk_id_low_byte: assert property (id_shown |->
		DQ[31:8] == '0) else $error("id code outside low byte");
	chk_cfg_single_read: assert property (cfg_shown |->
		DQ[31:7] == '0) else $error("config read shows stray bits");
	chk_otp_forward: assert property (otp_steady |->
		ARRAY_OTP == OTP_SELECT) else $error("otp select not forwarded");
endmodule : flash_read_checker

bind flash_read_top flash_read_checker u_chk (.CLK(CLK), .SRST(SRST),
	.RESET_N(RESET_N), .CHIP_SELECT_N(CHIP_SELECT_N),
	.OUTPUT_GATE_N(OUTPUT_GATE_N), .ID_MODE(ID_MODE), .CFG_READ(CFG_READ),
	.OTP_SELECT(OTP_SELECT), .DQ(DQ), .DQ_OE_N(DQ_OE_N),
	.BURST_END_FLAG_N(BURST_END_FLAG_N),
	.BURST_END_FLAG_OE_N(BURST_END_FLAG_OE_N), .ARRAY_ADDR(ARRAY_ADDR),
	.ARRAY_OTP(ARRAY_OTP));

// ---- sim/burst_flash_read_interface_bench.sv ----
// self-checking bench for the burst flash read interface
`timescale 1ns/1ps
module burst_flash_read_interface_bench;
	import flash_read_pkg::*;

	// identification codes: arbitrary values
	localparam logic [7:0] CODES [4] = '{8'h3c, 8'h41, 8'h52, 8'h63};
	localparam logic [3:0] SELS [5] = '{SEL_MFR, SEL_DEV1, SEL_DEV2,
		SEL_DEV3, SEL_PROT};

	logic                   clk, srst, reset_n, cs_n, og_n, av_n, bclk, hv;
	logic                   id_mode, cfg_rd, cfg_wr, cfg_en, otp, a_otp;
	logic                   dq_oe_n, fl_n, fl_oe_n;
	blen_t                  cfg_len;
	logic [DLY_W-1:0]       cfg_dly;
	logic [ADDR_W-1:0]      addr, a_addr;
	logic [DATA_W-1:0]      dq, a_rdata;
	logic [(1<<SECT_W)-1:0] prot;
	int                     error_cnt = 0;
	int                     num_checks = 0;

	flash_read_top #(.MFR_CODE(CODES[0]), .DEV_CODE1(CODES[1]),
		.DEV_CODE2(CODES[2]), .DEV_CODE3(CODES[3])) u_dut (
		.CLK(clk), .SRST(srst), .RESET_N(reset_n), .CHIP_SELECT_N(cs_n),
		.OUTPUT_GATE_N(og_n), .ADDRESS_VALID_N(av_n), .BURST_CLK(bclk),
		.ID_HIGH_VOLTAGE(hv), .ADDR(addr), .DQ(dq), .DQ_OE_N(dq_oe_n),
		.BURST_END_FLAG_N(fl_n), .BURST_END_FLAG_OE_N(fl_oe_n),
		.ID_MODE(id_mode), .CFG_READ(cfg_rd), .CFG_WRITE(cfg_wr),
		.CFG_BURST_EN(cfg_en), .CFG_LEN(cfg_len), .CFG_DELAY(cfg_dly),
		.OTP_SELECT(otp), .SECTOR_PROTECT(prot), .ARRAY_ADDR(a_addr),
		.ARRAY_OTP(a_otp), .ARRAY_RDATA(a_rdata));
	flash_array_model u_array (.clk(clk), .addr(a_addr), .otp(a_otp),
		.rdata(a_rdata));

	// ==========================================================
	// helpers
	function automatic logic [31:0] word(logic [18:0] a, logic o);
		return {o, 12'h5a5, a};
	endfunction : word

	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// burst clock kept slow: pins are sampled through synchronisers
	task automatic tick();
		bclk = 1;
		cyc(5);
		bclk = 0;
		cyc(5);
	endtask : tick

	task automatic check(logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	// capture on rise 0, data from rise n, two laps to see the wrap
	task automatic burst(blen_t l, logic [3:0] d, logic gate);
		logic [18:0] a;
		logic [2:0]  m, o;
		int          n, k;
		a = 19'($urandom);
		m = (l == BLEN_2) ? MASK_2 : (l == BLEN_4) ? MASK_4 : MASK_8;
		n = int'(d) + 2;
		cfg_wr = 1;
		cfg_en = 1;
		cfg_len = l;
		cfg_dly = d;
		addr = a;
		av_n = 0;
		cyc(1);
		cfg_wr = 0;
		cyc(4);
		for (k = 0; k <= n + 2 * (int'(m) + 1); k++) begin
			og_n = gate && (k == n + 1);
			tick();
			av_n = 1;
			o = 3'(int'(a[2:0]) + k - n) & m;
			if (og_n)
				check(dq_oe_n, 1);
			else if (k >= n) begin
				check(dq, word({a[18:3], (a[2:0] & ~m) | o}, otp));
				check(fl_oe_n, o != ((a[2:0] + m) & m));
				check(fl_n, 0);
			end
		end
		og_n = 0;
	endtask : burst

	// ==========================================================
	// stimulus
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	initial begin : main
		int          i;
		logic [18:0] a;
		i = $urandom(57410);
		srst = 1;
		reset_n = 1;
		cs_n = 1;
		og_n = 1;
		av_n = 1;
		bclk = 0;
		hv = 0;
		id_mode = 0;
		cfg_rd = 0;
		cfg_wr = 0;
		cfg_en = 0;
		cfg_len = BLEN_2;
		cfg_dly = 0;
		otp = 0;
		prot = {8{$urandom}};
		addr = 0;
		cyc(12);
		srst = 0;
		cyc(2);
		cs_n = 0;
		og_n = 0;
		repeat (4) begin
			addr = 19'($urandom);
			otp = 1'($urandom);
			cyc(8);
			check(dq, word(addr, otp));
			check(dq_oe_n, 0);
		end
		og_n = 1;
		cyc(6);
		check(dq_oe_n, 1);
		og_n = 0;
		$display("async reads done");
		for (i = 0; i < 5; i++) begin
			id_mode = i[0];
			hv = !i[0];
			a = 19'($urandom);
			a[6] = 0;
			a[3:0] = SELS[i];
			addr = a;
			cyc(8);
			check(dq, i < 4 ? CODES[i] : 8'(prot[a[18:11]]));
		end
		id_mode = 1;
		addr[6] = 1;
		cyc(8);
		check(dq, 0);
		id_mode = 0;
		hv = 0;
		$display("identification done");
		cfg_en = 1'($urandom);
		cfg_len = blen_t'($urandom % 3);
		cfg_dly = 4'($urandom);
		cfg_wr = 1;
		cyc(1);
		cfg_wr = 0;
		cfg_rd = 1;
		cyc(8);
		repeat (2) begin
			check(dq, {25'h0, cfg_dly, cfg_len, cfg_en});
			repeat (3) tick();
		end
		cfg_rd = 0;
		$display("config read done");
		burst(BLEN_2, 4'h0, 0);
		burst(BLEN_4, 4'hf, 1);
		burst(BLEN_8, 4'h1, 0);
		repeat (3) burst(blen_t'($urandom % 3), 4'($urandom % 6), 0);
		cs_n = 1;
		cyc(6);
		check(dq_oe_n, 1);
		check(fl_oe_n, 1);
		cs_n = 0;
		burst(BLEN_4, 4'h2, 0);
		$display("bursts done");
		reset_n = 0;
		cyc(6);
		check(dq_oe_n, 1);
		reset_n = 1;
		cyc(4);
		cfg_rd = 1;
		cyc(8);
		check(dq, {25'h0, 4'h0, BLEN_8, 1'b0});
		cfg_rd = 0;
		$display("reset pin done");
		conclude();
	end
endmodule : burst_flash_read_interface_bench
